// ===== src/raac_axil_slave.sv
// axi4-lite slave handshake for the region access registers
`timescale 1ns/100ps
`include "raac_regs.svh"
module raac_axil_slave
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [31:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic awready_q, wready_q, arready_q, bvalid_q, rvalid_q;
  logic bvalid_d, rvalid_d;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // address and data are held apart, so either may arrive first
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire wr_fire = aw_held_q & w_held_q;
  wire ar_take = s_axi_arvalid & arready_q;

  assign aw_held_d = wr_fire ? 1'b0 : (aw_held_q | aw_take);
  assign w_held_d = wr_fire ? 1'b0 : (w_held_q | w_take);
  assign bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready);
  assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);

  assign wr_en = wr_fire;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_en = ar_take;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= `RAAC_RST_WORD;
      wdata_q <= `RAAC_RST_WORD;
      wstrb_q <= 4'h0;
      rdata_q <= `RAAC_RST_WORD;
      bresp_q <= `RAAC_RESP_OKAY;
      rresp_q <= `RAAC_RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= ~aw_held_d & ~bvalid_d;
      wready_q <= ~w_held_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awaddr_q <= aw_take ? s_axi_awaddr : awaddr_q;
      wdata_q <= w_take ? s_axi_wdata : wdata_q;
      wstrb_q <= w_take ? s_axi_wstrb : wstrb_q;
      bresp_q <= wr_fire ? (wr_ok ? `RAAC_RESP_OKAY : `RAAC_RESP_SLVERR) : bresp_q;
      rdata_q <= ar_take ? rd_data : rdata_q;
      rresp_q <= ar_take ? (rd_ok ? `RAAC_RESP_OKAY : `RAAC_RESP_SLVERR) : rresp_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// ===== src/raac_perm_eval.sv
// effective permissions of the requesting master from the access word
`timescale 1ns/100ps
`include "raac_regs.svh"
module raac_perm_eval
(
  input wire logic [31:0] access_word,
  input wire logic [2:0] master,
  input wire logic supervisor,
  output raac_pkg::raac_perm_t eff_perm,
  output logic pid_enable
);
  import raac_pkg::*;

  raac_perm_t perm_by_master [8];
  logic [3:0] pe_by_master;

  // supervisor code decode, shared by masters 0 to 3
  function automatic raac_perm_t sup_decode(input logic [1:0] sm, input raac_perm_t um);
    raac_perm_t p;
    p = um;
    unique case (raac_sup_t'(sm))
      RAAC_SM_RWX: p = '{r: 1'b1, w: 1'b1, x: 1'b1};
      RAAC_SM_RX: p = '{r: 1'b1, w: 1'b0, x: 1'b1};
      RAAC_SM_RW: p = '{r: 1'b1, w: 1'b1, x: 1'b0};
      RAAC_SM_USER: p = um;
    endcase
    return p;
  endfunction

  genvar m;
  generate
    for (m = 0; m < 4; m++)
    begin : g_low
      wire raac_perm_t um = access_word[m*`RAAC_LOW_STRIDE+`RAAC_UM_LSB +: 3];
      wire [1:0] sm = access_word[m*`RAAC_LOW_STRIDE+`RAAC_SM_LSB +: 2];
      assign perm_by_master[m] = supervisor ? sup_decode(sm, um) : um;
      assign pe_by_master[m] = access_word[m*`RAAC_LOW_STRIDE+`RAAC_PE_BIT];
    end
    for (m = 4; m < 8; m++)
    begin : g_high
      // these masters have no fetch enable, so a fetch is judged as a read
      wire re = access_word[`RAAC_HI_BASE+(m-4)*`RAAC_HI_STRIDE+`RAAC_RE_OFS];
      wire we = access_word[`RAAC_HI_BASE+(m-4)*`RAAC_HI_STRIDE+`RAAC_WE_OFS];
      assign perm_by_master[m] = '{r: re, w: we, x: re};
    end
  endgenerate

  assign eff_perm = perm_by_master[master];
  assign pid_enable = master[2] ? 1'b0 : pe_by_master[master[1:0]];
endmodule

// ===== src/raac_pkg.sv
// types shared by the region access block
package raac_pkg;

  typedef struct packed
  {
    logic valid;
    logic [2:0] master;
    logic write;
    logic fetch;
    logic supervisor;
    logic [7:0] pid;
    logic [31:0] addr;
  } raac_req_t;

  typedef struct packed
  {
    logic r;
    logic w;
    logic x;
  } raac_perm_t;

  typedef enum logic [1:0]
  {
    RAAC_SM_RWX = 2'h0,
    RAAC_SM_RX = 2'h1,
    RAAC_SM_RW = 2'h2,
    RAAC_SM_USER = 2'h3
  } raac_sup_t;

endpackage

// ===== src/raac_regs.svh
// register offsets, field positions and reset values of the region access block
`ifndef RAAC_REGS_SVH
`define RAAC_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RAAC_OFS_START 8'h00
`define RAAC_OFS_END 8'h04
`define RAAC_OFS_ACCESS 8'h08
`define RAAC_OFS_PIDVLD 8'h0C
`define RAAC_OFS_ALT 8'h10
`define RAAC_OFS_STATUS 8'h14
`define RAAC_OFS_MASK 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define RAAC_LOW_STRIDE 6
`define RAAC_UM_LSB 0
`define RAAC_SM_LSB 3
`define RAAC_PE_BIT 5
`define RAAC_HI_BASE 24
`define RAAC_HI_STRIDE 2
`define RAAC_WE_OFS 0
`define RAAC_RE_OFS 1
`define RAAC_VLD_BIT 0
`define RAAC_PIDMASK_LSB 16
`define RAAC_PID_LSB 24
`define RAAC_EV_DENY 0
`define RAAC_EV_INVAL 1

// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define RAAC_RST_WORD 32'h00000000
`define RAAC_RST_EV 2'h0
`define RAAC_RESP_OKAY 2'h0
`define RAAC_RESP_SLVERR 2'h2

`endif

// ===== src/raac_top.sv
// region descriptor with alternate access-control view and access checker
//----------------------------------------
// What this block does
// - a write to the alternate location changes the access fields and never touches the valid bit
// - the alternate location and the access word are one 32-bit storage with one layout
// - masters 4 to 7 may read only while their read enable is set, else the read errors
// - masters 4 to 7 may write only while their write enable is set, else the write errors
// - masters 0 to 3 include the pid and its mask in the hit only while their pid enable is set
// - supervisor code 00 gives rwx, 01 gives r-x, 10 gives rw- for masters 0 to 3
// - supervisor code 11 gives exactly the user-mode rights of that master
// - user mode of masters 0 to 3 uses three independent r, w, x enable bits
// - an access whose right is clear errors unless another descriptor grants it
// - a write to descriptor words 0, 1 or 2 through the primary view clears the valid bit
// - new rights from the alternate location apply at once when its bus write completes
//----------------------------------------
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "raac_regs.svh"
module raac_top
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire raac_pkg::raac_req_t access_req,
  input wire logic other_grant,
  output logic check_done,
  output logic access_error,
  output logic region_hit,
  output logic region_violation,
  output logic irq
);
  import raac_pkg::*;

  //----------------------------------------
  // bus slave
  //----------------------------------------
  logic wr_en;
  logic rd_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_ok;

  raac_axil_slave u_slave
  (
    .clock(clock),
    .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  //----------------------------------------
  // address decode
  //----------------------------------------
  function automatic logic is_mapped(input logic [31:0] a);
    logic [7:0] ofs;
    ofs = a[7:0];
    return (a[31:8] == 24'h000000) &&
      ((ofs == `RAAC_OFS_START) || (ofs == `RAAC_OFS_END) ||
       (ofs == `RAAC_OFS_ACCESS) || (ofs == `RAAC_OFS_PIDVLD) ||
       (ofs == `RAAC_OFS_ALT) || (ofs == `RAAC_OFS_STATUS) ||
       (ofs == `RAAC_OFS_MASK));
  endfunction

  // byte lanes not strobed keep their old contents
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wr_ok = is_mapped(wr_addr);
  assign rd_ok = is_mapped(rd_addr);

  wire wr_hit = wr_en & wr_ok;
  wire wr_start = wr_hit & (wr_addr[7:0] == `RAAC_OFS_START);
  wire wr_end = wr_hit & (wr_addr[7:0] == `RAAC_OFS_END);
  wire wr_access = wr_hit & (wr_addr[7:0] == `RAAC_OFS_ACCESS);
  wire wr_pidvld = wr_hit & (wr_addr[7:0] == `RAAC_OFS_PIDVLD);
  wire wr_alt = wr_hit & (wr_addr[7:0] == `RAAC_OFS_ALT);
  wire wr_mask = wr_hit & (wr_addr[7:0] == `RAAC_OFS_MASK);
  wire rd_status = rd_en & rd_ok & (rd_addr[7:0] == `RAAC_OFS_STATUS);

  //----------------------------------------
  // descriptor storage
  //----------------------------------------
  logic [31:0] start_q;
  logic [31:0] start_d;
  logic [31:0] end_q;
  logic [31:0] end_d;
  logic [31:0] access_q;
  logic [31:0] access_d;
  logic [7:0] pid_q;
  logic [7:0] pid_d;
  logic [7:0] pid_mask_q;
  logic [7:0] pid_mask_d;
  logic valid_q;
  logic valid_d;
  logic [31:0] pidvld_merged;

  assign start_d = wr_start ? merge_strb(start_q, wr_data, wr_strb) : start_q;
  assign end_d = wr_end ? merge_strb(end_q, wr_data, wr_strb) : end_q;

  // one storage serves both views, only the valid side effect differs
  assign access_d = (wr_access | wr_alt) ? merge_strb(access_q, wr_data, wr_strb) : access_q;

  assign pidvld_merged = merge_strb({pid_q, pid_mask_q, 15'h0000, valid_q}, wr_data, wr_strb);
  assign pid_d = wr_pidvld ? pidvld_merged[`RAAC_PID_LSB +: 8] : pid_q;
  assign pid_mask_d = wr_pidvld ? pidvld_merged[`RAAC_PIDMASK_LSB +: 8] : pid_mask_q;

  // primary writes to words 0 to 2 drop the valid bit so a half-written descriptor never matches
  assign valid_d = wr_pidvld ? pidvld_merged[`RAAC_VLD_BIT] :
                   (wr_start | wr_end | wr_access) ? 1'b0 :
                   valid_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      start_q <= `RAAC_RST_WORD;
    end
    else
    begin
      start_q <= start_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      end_q <= `RAAC_RST_WORD;
    end
    else
    begin
      end_q <= end_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      access_q <= `RAAC_RST_WORD;
    end
    else
    begin
      access_q <= access_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pid_q <= 8'h00;
    end
    else
    begin
      pid_q <= pid_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pid_mask_q <= 8'h00;
    end
    else
    begin
      pid_mask_q <= pid_mask_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= valid_d;
    end
  end

  //----------------------------------------
  // access evaluation
  //----------------------------------------
  raac_perm_t eff_perm;
  logic pid_enable;

  // rights are taken straight from the stored word, so a finished write applies next cycle
  raac_perm_eval u_perm
  (
    .access_word(access_q),
    .master(access_req.master),
    .supervisor(access_req.supervisor),
    .eff_perm(eff_perm),
    .pid_enable(pid_enable)
  );

  wire in_range = (access_req.addr >= start_q) && (access_req.addr <= end_q);
  wire pid_match = ((access_req.pid | pid_mask_q) == (pid_q | pid_mask_q));
  wire pid_hit = ~pid_enable | pid_match;
  wire hit = valid_q & in_range & pid_hit;

  // fetch checks x, otherwise write checks w and read checks r
  wire violation = access_req.fetch ? ~eff_perm.x :
                   access_req.write ? ~eff_perm.w :
                   ~eff_perm.r;
  wire grant = hit & ~violation;
  wire allow = grant | other_grant;
  wire deny = access_req.valid & ~allow;

  logic check_done_q;
  logic access_error_q;
  logic region_hit_q;
  logic region_violation_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      check_done_q <= 1'b0;
      access_error_q <= 1'b0;
      region_hit_q <= 1'b0;
      region_violation_q <= 1'b0;
    end
    else
    begin
      check_done_q <= access_req.valid;
      access_error_q <= deny;
      region_hit_q <= access_req.valid & hit;
      region_violation_q <= access_req.valid & hit & violation;
    end
  end

  //----------------------------------------
  // events and interrupt
  //----------------------------------------
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic [1:0] ev_set;
  logic irq_q;

  assign ev_set[`RAAC_EV_DENY] = deny;
  assign ev_set[`RAAC_EV_INVAL] = valid_q & ~wr_pidvld & (wr_start | wr_end | wr_access);

  // a new event in the clearing read cycle survives the clear
  assign status_d = (rd_status ? 2'h0 : status_q) | ev_set;
  assign mask_d = wr_mask ? wr_data[1:0] & {2{wr_strb[0]}} | mask_q & {2{~wr_strb[0]}} : mask_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      status_q <= `RAAC_RST_EV;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_q <= `RAAC_RST_EV;
      irq_q <= 1'b0;
    end
    else
    begin
      mask_q <= mask_d;
      irq_q <= |(status_d & mask_d);
    end
  end

  //----------------------------------------
  // read data
  //----------------------------------------
  wire [7:0] rofs = rd_addr[7:0];
  assign rd_data = ~rd_ok ? `RAAC_RST_WORD :
                   (rofs == `RAAC_OFS_START) ? start_q :
                   (rofs == `RAAC_OFS_END) ? end_q :
                   (rofs == `RAAC_OFS_ACCESS) ? access_q :
                   (rofs == `RAAC_OFS_ALT) ? access_q :
                   (rofs == `RAAC_OFS_PIDVLD) ? {pid_q, pid_mask_q, 15'h0000, valid_q} :
                   (rofs == `RAAC_OFS_STATUS) ? {30'h0, status_q} :
                   {30'h0, mask_q};

  assign check_done = check_done_q;
  assign access_error = access_error_q;
  assign region_hit = region_hit_q;
  assign region_violation = region_violation_q;
  assign irq = irq_q;
endmodule

// ===== tb/raac_master_model.sv
// model of the crossbar masters presenting accesses
`timescale 1ns/100ps
module raac_master_model
(
  input wire logic clock,
  input wire logic nrst,
  input wire raac_pkg::raac_req_t cmd,
  input wire logic cmd_grant,
  output raac_pkg::raac_req_t req,
  output logic grant
);
  import raac_pkg::*;
  // idle cycles carry changing junk so nothing may lean on stale fields
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      req <= '0;
      grant <= 1'b0;
    end
    else
    begin
      req <= cmd.valid ? cmd : {1'b0, ~req[45:0]};
      grant <= cmd.valid ? cmd_grant : ~grant;
    end
  end
endmodule

// ===== tb/raac_top_assertions.sv
// port checker of the region access block
`timescale 1ns/100ps
module raac_top_assertions
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire raac_pkg::raac_req_t access_req,
  input wire logic other_grant,
  input wire logic check_done,
  input wire logic access_error,
  input wire logic region_hit,
  input wire logic region_violation
);
  import raac_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // access check timing and verdict
  // ----------------------------------------
  a_done_follows_req: assert property (access_req.valid |=> check_done)
    else $error("no check_done after a request");
  a_idle_no_done: assert property (!access_req.valid |=> !check_done)
    else $error("check_done without a request");
  a_error_needs_done: assert property (access_error |-> check_done)
    else $error("access_error outside check_done");
  a_grant_no_error: assert property (access_req.valid && other_grant |=> !access_error)
    else $error("error despite a grant elsewhere");
  a_error_from_hit: assert property (access_req.valid && !other_grant |=>
    access_error == (!region_hit || region_violation))
    else $error("access_error disagrees with hit and violation");
  a_violation_in_hit: assert property (region_violation |-> region_hit)
    else $error("violation reported on a miss");
  // ----------------------------------------
  // register bus answers
  // ----------------------------------------
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule
bind raac_top raac_top_assertions u_chk (.clock(clock), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .access_req(access_req), .other_grant(other_grant), .check_done(check_done),
  .access_error(access_error), .region_hit(region_hit), .region_violation(region_violation));

// ===== tb/tb_region_alt_access_control.sv
// self-checking bench of the region access block
`timescale 1ns/100ps
`include "raac_regs.svh"
module tb_region_alt_access_control;
  import raac_pkg::*;
  logic clock, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata, word, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic cgrant, grant, done, err, hit, viol, irq, vld, den;
  raac_req_t cmd, req, q;
  int err_total, cmp_count, seed, i, j;
  raac_top u_dut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .access_req(req),
    .other_grant(grant), .check_done(done), .access_error(err), .region_hit(hit),
    .region_violation(viol), .irq(irq));
  raac_master_model u_mst (.clock(clock), .nrst(nrst), .cmd(cmd), .cmd_grant(cgrant), .req(req), .grant(grant));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----------------------------------------
  // bus, compare and expectation helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // ready is looked at on the falling edge, where the flop value is settled until the taking edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clock);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clock);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    while (!tb);
  endtask
  task automatic axr(input logic [7:0] a);
    logic ta, tr, rv;
    @(posedge clock);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    // some offsets raise rready only once rvalid is seen, so the slave must hold its answer
    rready <= a[3];
    do
    begin
      @(negedge clock);
      ta = arvalid & arready;
      rv = rvalid;
      tr = rv & rready;
      rd = rdata;
      rsp = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      rready <= ~tr & (rready | rv);
    end
    while (!tr);
  endtask
  function automatic logic [2:0] eperm(input logic [31:0] w, input logic [2:0] m, input logic s);
    logic [1:0] c;
    if (m[2]) return {w[2*m+17], w[2*m+16], w[2*m+17]};
    c = w[6*m+3 +: 2];
    if (!s || c == RAAC_SM_USER) return w[6*m +: 3];
    return c == RAAC_SM_RWX ? 3'h7 : c == RAAC_SM_RX ? 3'h5 : 3'h6;
  endfunction
  function automatic logic ehit(input raac_req_t r);
    logic h;
    h = vld && r.addr >= 32'h1000 && r.addr <= 32'h1FFF;
    if (!r.master[2] && word[6*r.master+5]) h = h && ((r.pid | 8'h0F) == 8'h5F);
    return h;
  endfunction
  function automatic logic eviol(input raac_req_t r);
    logic [2:0] p;
    p = eperm(word, r.master, r.supervisor);
    return ehit(r) && !(r.write ? p[1] : r.fetch ? p[0] : p[2]);
  endfunction
  function automatic logic edeny(input raac_req_t r, input logic g);
    return (!ehit(r) || eviol(r)) && !g;
  endfunction
  task automatic acc(input raac_req_t r, input logic g);
    @(posedge clock);
    cmd <= r;
    cgrant <= g;
    @(posedge clock);
    cmd.valid <= 1'b0;
    @(posedge clock);
    #1;
    den = den | edeny(r, g);
    chk("check_done", 32'h1, {31'h0, done});
    chk("access_error", {31'h0, edeny(r, g)}, {31'h0, err});
    chk("region_hit", {31'h0, ehit(r)}, {31'h0, hit});
    chk("region_violation", {31'h0, eviol(r)}, {31'h0, viol});
  endtask
  task automatic rnd_acc(input logic [31:0] a);
    q = 47'({$random(seed), $random(seed)});
    q.valid = 1'b1;
    q.fetch = q.fetch & ~q.write;
    q.addr = a;
    acc(q, ($random(seed) & 7) == 0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, cgrant, vld, den} = '0;
    {awaddr, wdata, araddr} = '0;
    cmd = '0;
    wstrb = 4'hF;
    word = 32'h0;
    seed = 97571;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    axw(`RAAC_OFS_START, 32'h1000);
    axw(`RAAC_OFS_END, 32'h1FFF);
    axw(`RAAC_OFS_MASK, 32'h3);
    axr(`RAAC_OFS_STATUS);
    axw(`RAAC_OFS_PIDVLD, 32'h5A0F0001);
    vld = 1'b1;
    for (i = 0; i < 40; i++)
    begin
      word = $random(seed);
      axw(`RAAC_OFS_ALT, word);
      chk("alt bresp", 32'h0, {30'h0, rsp});
      axr(`RAAC_OFS_ACCESS);
      chk("access word", word, rd);
      axr(`RAAC_OFS_PIDVLD);
      chk("valid kept", 32'h5A0F0001, rd);
      for (j = 0; j < 8; j++)
        rnd_acc({19'h0, 13'($random(seed))});
      chk("irq", {31'h0, den}, {31'h0, irq});
      axr(`RAAC_OFS_STATUS);
      chk("status", {31'h0, den}, rd);
      den = 1'b0;
    end
    // region edges with every right granted
    word = 32'hFFFFFFFF;
    axw(`RAAC_OFS_ALT, word);
    for (i = 0; i < 4; i++)
      rnd_acc(32'h0FFF + (i[1] ? 32'h1000 : 32'h0) + i[0]);
    // status emptied first, so the irq below can only come from the invalidation
    axr(`RAAC_OFS_STATUS);
    chk("status edges", {31'h0, den}, rd);
    // a primary write drops the descriptor out of use
    axw(`RAAC_OFS_ACCESS, word);
    vld = 1'b0;
    axr(`RAAC_OFS_PIDVLD);
    chk("valid cleared", 32'h5A0F0000, rd);
    chk("irq on clear", 32'h1, {31'h0, irq});
    rnd_acc(32'h1800);
    axr(`RAAC_OFS_STATUS);
    chk("status clear", 32'h2, rd & 32'h2);
    axr(8'h1C);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped resp", 32'h2, {30'h0, rsp});
    complete_run;
  end
  initial
  begin
    #200000;
    err_total++;
    complete_run;
  end
endmodule
